// file: rtl/pfd_pkg.sv
// shared code-group constants, states and carrier types of the frame delimiter
package pfd_pkg;

    // one 8b/10b code-group before encoding: control flag plus octet
    typedef struct packed {
        logic       k;
        logic [7:0] d;
    } pfd_cg_t;

    // code-groups used on the line side
    localparam pfd_cg_t CG_K28_5 = {1'b1, 8'hbc};  // comma
    localparam pfd_cg_t CG_D21_5 = {1'b0, 8'hb5};  // config type one
    localparam pfd_cg_t CG_D2_2  = {1'b0, 8'h42};  // config type two
    localparam pfd_cg_t CG_D5_6  = {1'b0, 8'hc5};  // correcting idle
    localparam pfd_cg_t CG_D16_2 = {1'b0, 8'h50};  // preserving idle
    localparam pfd_cg_t CG_EXT   = {1'b1, 8'hf7};  // carrier extend
    localparam pfd_cg_t CG_SOP   = {1'b1, 8'hfb};  // start of packet
    localparam pfd_cg_t CG_EOP   = {1'b1, 8'hfd};  // end of packet
    localparam pfd_cg_t CG_ERR   = {1'b1, 8'hfe};  // error propagation

    // client side byte values
    localparam logic [7:0] PFD_PREAMBLE = 8'h55;
    localparam logic [7:0] PFD_FRM_EXT  = 8'h0f;

    // configuration set word indices
    localparam logic [1:0] CFG_COMMA = 2'h0;
    localparam logic [1:0] CFG_TYPE  = 2'h1;
    localparam logic [1:0] CFG_LO    = 2'h2;
    localparam logic [1:0] CFG_HI    = 2'h3;

    typedef enum logic [2:0] {TX_IDLE, TX_CFG, TX_SOP, TX_DATA, TX_EXT} pfd_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_T, RX_TR} pfd_rx_st_t;

    // gmii receive bundle
    typedef struct packed {
        logic [7:0] rxd;
        logic       dv;
        logic       er;
    } pfd_gmii_rx_t;

    // whole state of the block
    typedef struct packed {
        pfd_tx_st_t   tx;
        logic         odd;       // position of the code-group now chosen
        logic         first_idle;
        logic         ext_more;  // a second extend still owed
        logic [1:0]   cfg_idx;
        logic         cfg_two;   // current set is type two
        pfd_cg_t      tx_cg;
        pfd_rx_st_t   rx;
        pfd_gmii_rx_t gmii_rx;
    } pfd_state_t;

endpackage

// file: rtl/pfd_top.sv
// 1000base-x frame delimiter: gmii to ordered sets and back
//
// Function
// - during configuration the transmitter alternates type one and type two sets.
// - each set is comma, type character, then the two config register bytes.
// - idles are comma plus D5.6 (correcting) or comma plus D16.2 (preserving).
// - extend, start, end and error are the single K23.7, K27.7, K29.7, K30.7 groups.
// - the idle comma sits in an even position and its second character in an odd one.
// - enable rising in an even position with cfg_en_i low sends start of packet for the first preamble byte.
// - enable rising in an odd position sends D16.2 then start of packet for the second byte.
// - a received start of packet becomes one preamble byte on the client side.
// - the receiver never recreates the preamble byte dropped on an odd start.
// - the first cycle with enable low after a frame sends end of packet at once.
// - the even/odd alignment set at start of packet holds through end of packet.
// - end of packet in an even position is followed by exactly one extend.
// - end of packet in an odd position is followed by exactly two extends.
// - the idle right after the extends is correcting if disparity is positive and enable stays low, else preserving.
// - end, extend, extend received gives one cycle of receive error with data 0x0F.
`timescale 1ns/10ps
`default_nettype none

module pfd_top
    import pfd_pkg::*;
(
    // clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // gmii transmit from the mac
    input  wire logic [7:0] gmii_txd_i,
    input  wire logic     gmii_tx_en_i,
    input  wire logic     gmii_tx_er_i,
    // control from auto-negotiation and the encoder
    input  wire logic     cfg_en_i,
    input  wire logic [15:0] cfg_reg_i,
    input  wire logic     rd_pos_i,
    // line side
    output logic [8:0]    tx_cg_o,
    input  wire logic [8:0] rx_cg_i,
    // gmii receive to the mac
    output logic [7:0]    gmii_rxd_o,
    output logic          gmii_rx_dv_o,
    output logic          gmii_rx_er_o
);

    pfd_state_t st_q;
    pfd_state_t st_d;
    pfd_cg_t    rx_cg;

    assign rx_cg = pfd_cg_t'(rx_cg_i);

    // second character of an idle, chosen by disparity only right after a frame
    function automatic pfd_cg_t idle_second(input logic first, input logic rd_pos);
        idle_second = (first && rd_pos) ? CG_D5_6 : CG_D16_2;
    endfunction

    // next state: transmit and receive engines side by side
    always_comb begin
        st_d          = st_q;
        st_d.odd      = ~st_q.odd;  // alternates every group, frames included
        st_d.gmii_rx.er = 1'b0;
        // transmit engine
        unique case (st_q.tx)
            TX_IDLE: begin
                if (!st_q.odd) begin
                    st_d.tx_cg = CG_K28_5;
                    if (cfg_en_i) begin
                        st_d.tx         = TX_CFG;
                        st_d.cfg_idx    = CFG_TYPE;
                        st_d.first_idle = 1'b0;
                    end
                    if (gmii_tx_en_i && !cfg_en_i) begin
                        st_d.tx_cg      = CG_SOP;
                        st_d.tx         = TX_DATA;
                        st_d.first_idle = 1'b0;
                    end
                end else if (gmii_tx_en_i) begin
                    // idle must be finished first; this preamble byte is lost
                    st_d.tx_cg      = CG_D16_2;
                    st_d.tx         = TX_SOP;
                    st_d.first_idle = 1'b0;
                end else begin
                    st_d.tx_cg      = idle_second(st_q.first_idle, rd_pos_i);
                    st_d.first_idle = 1'b0;
                end
            end
            TX_CFG: begin
                unique case (st_q.cfg_idx)
                    CFG_COMMA: st_d.tx_cg = CG_K28_5;
                    CFG_TYPE:  st_d.tx_cg = st_q.cfg_two ? CG_D2_2 : CG_D21_5;
                    CFG_LO:    st_d.tx_cg = {1'b0, cfg_reg_i[7:0]};
                    CFG_HI:    st_d.tx_cg = {1'b0, cfg_reg_i[15:8]};
                endcase
                st_d.cfg_idx = st_q.cfg_idx + 2'h1;
                if (st_q.cfg_idx == CFG_HI) begin
                    st_d.cfg_two = ~st_q.cfg_two;
                    // sets are never cut short; leave only on a set boundary
                    if (!cfg_en_i) st_d.tx = TX_IDLE;
                end
            end
            TX_SOP: begin
                st_d.tx_cg = CG_SOP;
                st_d.tx    = TX_DATA;
            end
            TX_DATA: begin
                if (!gmii_tx_en_i) begin
                    st_d.tx_cg    = CG_EOP;
                    st_d.tx       = TX_EXT;
                    st_d.ext_more = st_q.odd;
                end else begin
                    st_d.tx_cg = gmii_tx_er_i ? CG_ERR : {1'b0, gmii_txd_i};
                end
            end
            TX_EXT: begin
                st_d.tx_cg    = CG_EXT;
                st_d.ext_more = 1'b0;
                if (!st_q.ext_more) begin
                    st_d.tx         = TX_IDLE;
                    st_d.first_idle = 1'b1;
                end
            end
            default: st_d.tx = TX_IDLE;
        endcase
        // receive engine
        unique case (st_q.rx)
            RX_IDLE: begin
                st_d.gmii_rx.dv = 1'b0;
                if (rx_cg == CG_SOP) begin
                    // only the start group becomes preamble, nothing else is restored
                    st_d.gmii_rx.rxd = PFD_PREAMBLE;
                    st_d.gmii_rx.dv  = 1'b1;
                    st_d.rx          = RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_cg == CG_EOP) begin
                    st_d.gmii_rx.dv = 1'b0;
                    st_d.rx         = RX_T;
                end else begin
                    st_d.gmii_rx.rxd = rx_cg.d;
                    st_d.gmii_rx.er  = (rx_cg == CG_ERR);
                end
            end
            RX_T: st_d.rx = (rx_cg == CG_EXT) ? RX_TR : RX_IDLE;
            RX_TR: begin
                st_d.rx = RX_IDLE;
                if (rx_cg == CG_EXT) begin
                    st_d.gmii_rx.rxd = PFD_FRM_EXT;
                    st_d.gmii_rx.er  = 1'b1;
                end
            end
        endcase
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q            <= '0;
            st_q.tx         <= TX_IDLE;
            st_q.rx         <= RX_IDLE;
            st_q.tx_cg      <= CG_D16_2;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign tx_cg_o      = st_q.tx_cg;
    assign gmii_rxd_o   = st_q.gmii_rx.rxd;
    assign gmii_rx_dv_o = st_q.gmii_rx.dv;
    assign gmii_rx_er_o = st_q.gmii_rx.er;

    // position of the group now on tx_cg_o is the opposite of the one being chosen
    logic out_even;
    assign out_even = st_q.odd;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_odd_start;
        (st_q.tx == TX_IDLE) && st_q.odd && gmii_tx_en_i && !cfg_en_i;
    endsequence
    sequence s_d16_then_sop;
        (tx_cg_o == CG_D16_2) ##1 (tx_cg_o == CG_SOP);
    endsequence
    sequence s_rx_trr;
        (st_q.rx == RX_DATA) && (rx_cg == CG_EOP) ##1 (rx_cg == CG_EXT) ##1 (rx_cg == CG_EXT);
    endsequence

    chk_comma_even: assert property (tx_cg_o == CG_K28_5 |-> out_even)
        else $error("comma left the even position");
    chk_sop_even: assert property (tx_cg_o == CG_SOP |-> out_even)
        else $error("start of packet in odd position");
    chk_odd_start: assert property (s_odd_start |=> s_d16_then_sop)
        else $error("odd start not completed by D16.2 then start");
    chk_eop_now: assert property ((st_q.tx == TX_DATA) && !gmii_tx_en_i |=> tx_cg_o == CG_EOP)
        else $error("end of packet not sent at once");
    chk_ext_even: assert property ((tx_cg_o == CG_EOP) && out_even
        |=> (tx_cg_o == CG_EXT) ##1 (tx_cg_o == CG_K28_5))
        else $error("even end not followed by one extend");
    chk_ext_odd: assert property ((tx_cg_o == CG_EOP) && !out_even
        |=> (tx_cg_o == CG_EXT) [*2] ##1 (tx_cg_o == CG_K28_5))
        else $error("odd end not followed by two extends");
    chk_rx_sop: assert property ((st_q.rx == RX_IDLE) && (rx_cg == CG_SOP)
        |=> gmii_rx_dv_o && (gmii_rxd_o == PFD_PREAMBLE))
        else $error("start not turned into preamble");
    chk_rx_frm_ext: assert property (s_rx_trr |=> gmii_rx_er_o && (gmii_rxd_o == PFD_FRM_EXT)
        ##1 !gmii_rx_er_o)
        else $error("frame extension not signalled for one cycle");
    chk_cfg_alt: assert property ((tx_cg_o == CG_D21_5) && (st_q.tx == TX_CFG)
        |-> ##4 (tx_cg_o == CG_D2_2) || (st_q.tx != TX_CFG))
        else $error("configuration sets do not alternate");

    // idle second character: disparity matters only right after a frame
    chk_idle_corr: assert property ((st_q.tx == TX_IDLE) && st_q.odd && !gmii_tx_en_i
        && st_q.first_idle && rd_pos_i |=> tx_cg_o == CG_D5_6)
        else $error("first idle after frame not correcting");
    chk_idle_pres: assert property ((st_q.tx == TX_IDLE) && st_q.odd && !gmii_tx_en_i
        && !st_q.first_idle |=> tx_cg_o == CG_D16_2)
        else $error("later idle not preserving");

endmodule // pfd_top

`default_nettype wire

// file: test/pcs_frame_delimiter_encoding_tb.sv
// bench: frames looped from line output back to line input
`timescale 1ns/10ps
`default_nettype none
module pcs_frame_delimiter_encoding_tb;
    import pfd_pkg::*;
    logic       clk, rst, tx_en, tx_er, cfg_en, rd_pos, dv, rer, even_next, armed;
    logic [7:0] txd, rxd;
    logic [15:0] cfg_reg;
    logic [8:0] tx_cg;
    logic [8:0] exp_q[$];
    logic [8:0] rx_q[$];
    int bad_count, samples_checked, cycles, ext_seen, ext_exp;
    int rows[5][4] = '{'{6,0,0,-1}, '{5,0,1,-1}, '{5,1,1,-1}, '{6,1,0,-1}, '{3,0,1,-1}};

    pfd_mac_model mac (.clk_i(clk), .gmii_txd_o(txd), .gmii_tx_en_o(tx_en), .gmii_tx_er_o(tx_er));
    pfd_top dut (.clk_i(clk), .rst_i(rst), .gmii_txd_i(txd), .gmii_tx_en_i(tx_en),
        .gmii_tx_er_i(tx_er), .cfg_en_i(cfg_en), .cfg_reg_i(cfg_reg), .rd_pos_i(rd_pos),
        .tx_cg_o(tx_cg), .rx_cg_i(tx_cg), .gmii_rxd_o(rxd), .gmii_rx_dv_o(dv),
        .gmii_rx_er_o(rer));

    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // expected line stream and client bytes of one frame
    task automatic plan(input int len, input bit odd, input bit rd, input int eri);
        logic [8:0] b;
        exp_q = {};
        rx_q = {};
        ext_seen = 0;
        if (odd) exp_q.push_back(CG_D16_2);
        exp_q.push_back(CG_SOP);
        rx_q.push_back({1'b0, PFD_PREAMBLE});
        for (int i = odd + 1; i < len; i++) begin
            b = {1'b0, 8'h30 + 8'(i)};
            exp_q.push_back(i == eri ? 9'(CG_ERR) : b);
            rx_q.push_back(i == eri ? 9'h100 : b);
        end
        ext_exp = (odd + len) % 2;  // end position follows the start alignment
        exp_q.push_back(CG_EOP);
        exp_q.push_back(CG_EXT);
        if (ext_exp == 1) exp_q.push_back(CG_EXT);
        exp_q.push_back(CG_K28_5);
        exp_q.push_back(rd ? 9'(CG_D5_6) : 9'(CG_D16_2));
        exp_q.push_back(CG_K28_5);
        exp_q.push_back(CG_D16_2);
    endtask
    // start at the wanted position, then drain and tally
    task automatic run(input int len, input bit odd, input bit rd, input int eri);
        plan(len, odd, rd, eri);
        rd_pos = rd;
        @(negedge clk);
        while (even_next == odd) @(negedge clk);
        armed = 1'b1;
        mac.send(len, eri);
        repeat (8) @(negedge clk);
        armed = 1'b0;
        check(9'(exp_q.size() + rx_q.size()), 9'h000, "left over");
        check(9'(ext_seen), 9'(ext_exp), "extension count");
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(negedge clk);
        check(tx_cg, CG_D16_2, "reset line");
        check({rxd, dv}, 9'h000, "reset rx");
        check({8'h00, rer}, 9'h000, "reset er");
        rst = 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog: a hang counts as a mismatch and ends the run
    always @(posedge clk) begin
        if (cycles > 3000) begin
            bad_count++;
            conclude();
        end
    end
    // line and client monitor, one look per cycle after the edge settles
    always @(posedge clk) begin
        #1;
        cycles++;
        even_next = rst ? 1'b1 : ~even_next;
        if (armed && exp_q.size() > 0) check(tx_cg, exp_q.pop_front(), "line");
        if (dv === 1'b1 && rx_q.size() > 0) begin
            check({rer, rx_q[0][8] ? 8'h00 : rxd}, rx_q[0], "rx byte");
            void'(rx_q.pop_front());
        end else if (dv === 1'b1) check({rer, rxd}, 9'h1ff, "rx extra");
        else if (rer === 1'b1) begin
            ext_seen++;
            check({1'b0, rxd}, {1'b0, PFD_FRM_EXT}, "extension");
        end
    end

    initial begin
        {rst, cfg_en, rd_pos, armed, even_next} = 5'h10;
        cfg_reg = 16'hc3a5;
        {bad_count, samples_checked, cycles, ext_seen, ext_exp} = 0;
        do_reset();
        foreach (rows[r]) run(rows[r][0], rows[r][1][0], rows[r][2][0], rows[r][3]);
        run(7, 0, 0, 3);
        // configuration sets alternate type one and two
        @(negedge clk);
        while (even_next !== 1'b1) @(negedge clk);
        exp_q = {9'(CG_K28_5), 9'(CG_D21_5), 9'h0a5, 9'h0c3,
                 9'(CG_K28_5), 9'(CG_D2_2), 9'h0a5, 9'h0c3};
        cfg_en = 1'b1;
        armed = 1'b1;
        repeat (6) @(negedge clk);
        cfg_en = 1'b0;  // dropped mid set, the set still completes
        repeat (2) @(negedge clk);
        armed = 1'b0;
        check(9'(exp_q.size()), 9'h000, "config left");
        do_reset();
        run(4, 1, 1, -1);
        conclude();
    end
endmodule // pcs_frame_delimiter_encoding_tb
`default_nettype wire

// file: test/pfd_mac_model.sv
// mac model: drives gmii transmit frames at the falling edge
`timescale 1ns/10ps
`default_nettype none
module pfd_mac_model (
    // clock
    input  wire logic  clk_i,
    // gmii transmit
    output logic [7:0] gmii_txd_o,
    output logic       gmii_tx_en_o,
    output logic       gmii_tx_er_o
);
    // idle at time zero
    initial begin
        gmii_txd_o   = 8'h00;
        gmii_tx_en_o = 1'b0;
        gmii_tx_er_o = 1'b0;
    end
    // one frame, byte i = 0x30+i, error flagged on byte er_idx
    task automatic send(input int len, input int er_idx);
        for (int i = 0; i < len; i++) begin
            gmii_tx_en_o = 1'b1;
            gmii_txd_o   = 8'h30 + 8'(i);
            gmii_tx_er_o = (i == er_idx);
            @(negedge clk_i);
        end
        gmii_tx_en_o = 1'b0;
        gmii_tx_er_o = 1'b0;
        gmii_txd_o   = ~gmii_txd_o;  // stale byte must not look valid
    endtask
endmodule // pfd_mac_model
`default_nettype wire
